// ==== pkg/fsl_regs.svh ====
// Constants of the flash security option loader: register indices, field
// positions, reset values and the nonvolatile read sequence.
// Assumes a byte-wide nonvolatile array read port and an APB host.
//
// Summary of operation
// R1: Every reset copies nonvolatile protection and option bytes to working.
// R2: The eight-byte backdoor key lives at 0xFFB0 to 0xFFB7.
// R3: Key enable at one: a matching key releases security temporarily.
// R4: Key entry only from secure code, never through background debug.
// R5: Key enable programmed to zero disables the key path fully.
// R6: Without the key path, release needs mass erase then blank verify.
// R7: Security field 1:0 loaded at reset means unsecured.
// R8: Other security values report secured until key match or erase.
`ifndef FSL_REGS_SVH
`define FSL_REGS_SVH

// ---------------------------------------------------------------------------
// Register indices; byte address on APB is four times the index.
// ---------------------------------------------------------------------------
`define FSL_IDX_OPT       16'h1821
`define FSL_IDX_CFG       16'h1823
`define FSL_IDX_PROT      16'h1824
`define FSL_IDX_STATUS    16'h1830
`define FSL_IDX_KEY_FIRST 16'hFFB0
`define FSL_IDX_KEY_LAST  16'hFFB7
`define FSL_IDX_NV_PROT   16'hFFBD
`define FSL_IDX_NV_OPT    16'hFFBF

// ---------------------------------------------------------------------------
// Field positions and values.
// ---------------------------------------------------------------------------
`define FSL_OPT_KEY_EN    7
`define FSL_OPT_NORED     6
`define FSL_CFG_KEY_ACC   5
`define FSL_PROT_DIS      0
`define FSL_SEC_UNSECURED 2'h2
`define FSL_ST_SECURED    0
`define FSL_ST_LOADED     1
`define FSL_ST_KEY_FAIL   2
`define FSL_ST_KEY_REFUSE 3
`define FSL_ST_ERASED     4
`define FSL_RESET_BYTE    8'h00
`define FSL_KEY_BYTES     8
`define FSL_LOAD_LAST     4'h9

`endif

// ==== pkg/fsl_pkg.sv ====
// Types shared by the flash security option loader modules.
// Assumes fsl_regs.svh holds the numeric constants.
package fsl_pkg;

  typedef logic [7:0] fsl_byte_t;

  typedef enum logic {
    LD_BUSY = 1'b0,
    LD_DONE = 1'b1
  } fsl_load_state_t;

endpackage : fsl_pkg

// ==== pkg/fsl_ld_if.sv ====
// Carries the bytes copied from the nonvolatile array at reset.
// Assumes one loader drives it and the register block reads it.
`timescale 1ns/10ps
interface fsl_ld_if;
  logic [63:0] key;
  logic [7:0]  prot;
  logic [7:0]  opt;
  logic        done;

  modport loader (output key, output prot, output opt, output done);
  modport user   (input key, input prot, input opt, input done);
endinterface : fsl_ld_if

// ==== src/fsl_nv_loader.sv ====
// Reads the key, protection and option bytes from the nonvolatile array
// after every reset. Assumes the array answers each held request with
// a one-cycle valid and the addressed byte.
`timescale 1ns/10ps
`include "fsl_regs.svh"
module fsl_nv_loader
  import fsl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Nonvolatile read port
  output logic             nv_req_o,
  output logic [15:0]      nv_addr_o,
  input  wire fsl_byte_t   nv_data_i,
  input  wire logic        nv_valid_i,
  // Loaded values
  fsl_ld_if.loader         ld
);
  fsl_load_state_t state_q;
  logic [3:0]      cnt_q;
  logic [3:0]      cnt_d;

  function automatic logic [15:0] seq_addr(input logic [3:0] n);
    if (n < 4'h8) return `FSL_IDX_KEY_FIRST + {12'h000, n};
    else if (n == 4'h8) return `FSL_IDX_NV_PROT;
    else return `FSL_IDX_NV_OPT;
  endfunction : seq_addr

  assign cnt_d    = cnt_q + 4'h1;
  assign nv_req_o = (state_q == LD_BUSY);
  assign ld.done  = (state_q == LD_DONE);

  // R1: copy at reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q   <= LD_BUSY;
      cnt_q     <= 4'h0;
      nv_addr_o <= `FSL_IDX_KEY_FIRST;
      ld.key    <= 64'h0;
      ld.prot   <= `FSL_RESET_BYTE;
      ld.opt    <= `FSL_RESET_BYTE;
    end else if (state_q == LD_BUSY && nv_valid_i) begin
      // R2: key bytes in order
      if (cnt_q < 4'h8) ld.key[cnt_q[2:0]*8 +: 8] <= nv_data_i;
      else if (cnt_q == 4'h8) ld.prot <= nv_data_i;
      else ld.opt <= nv_data_i;
      if (cnt_q == `FSL_LOAD_LAST) state_q <= LD_DONE;
      cnt_q     <= cnt_d;
      nv_addr_o <= seq_addr(cnt_d);
    end
  end
endmodule : fsl_nv_loader

// ==== src/fsl_key_cmp.sv ====
// Collects the eight backdoor key bytes written by software and compares
// them with the stored key when the entry window closes.
// Assumes the caller only passes writes it has already qualified.
`timescale 1ns/10ps
`include "fsl_regs.svh"
module fsl_key_cmp
  import fsl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Entry control
  input  wire logic        clear_i,
  input  wire logic        wr_i,
  input  wire logic [2:0]  idx_i,
  input  wire fsl_byte_t   data_i,
  input  wire logic        check_i,
  input  wire logic [63:0] key_i,
  // Result
  output logic             match_o,
  output logic             fail_o
);
  logic [63:0] entry_q;
  logic [7:0]  seen_q;
  logic        good_w;

  // An erased or blank key never matches, so an unprogrammed part stays shut.
  assign good_w = (entry_q == key_i) && (&seen_q) &&
                  (key_i != 64'h0) && (key_i != 64'hFFFF_FFFF_FFFF_FFFF);

  for (genvar b = 0; b < `FSL_KEY_BYTES; b++) begin : g_lane
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        entry_q[b*8 +: 8] <= 8'h00;
        seen_q[b]         <= 1'b0;
      end else if (clear_i) begin
        seen_q[b]         <= 1'b0;
      end else if (wr_i && idx_i == 3'(b)) begin
        entry_q[b*8 +: 8] <= data_i;
        seen_q[b]         <= 1'b1;
      end
    end
  end

  // R3: compare on close
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      match_o <= 1'b0;
      fail_o  <= 1'b0;
    end else begin
      match_o <= check_i && good_w;
      fail_o  <= check_i && !good_w;
    end
  end
endmodule : fsl_key_cmp

// ==== src/fsl_flash_security.sv ====
// Top of the flash security option loader: APB register slave, security
// state and block protection outputs.
// Assumes an APB master on clk_i and a nonvolatile array read port; the
// execution-source flags come from the CPU on the same clock.
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`include "fsl_regs.svh"
module fsl_flash_security
  import fsl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // APB slave
  input  wire logic [17:0] paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Nonvolatile array read port
  output logic             nv_req_o,
  output logic [15:0]      nv_addr_o,
  input  wire fsl_byte_t   nv_data_i,
  input  wire logic        nv_valid_i,
  // Access source and erase events
  input  wire logic        secure_exec_i,
  input  wire logic        debug_access_i,
  input  wire logic        mass_erase_done_i,
  input  wire logic        blank_verified_i,
  // Security and protection state
  output logic             secured_o,
  output logic             load_done_o,
  output logic             key_enable_o,
  output logic             vector_redirect_disable_o,
  output logic             protection_disable_o,
  output logic [6:0]       protect_select_o
);

  // -------------------------------------------------------------------------
  // Address decode
  // -------------------------------------------------------------------------

  function automatic logic [17:0] byte_addr(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction : byte_addr

  logic        setup_w;
  logic        access_w;
  logic        wr_w;
  logic        rd_w;
  logic        hit_opt_w;
  logic        hit_cfg_w;
  logic        hit_prot_w;
  logic        hit_stat_w;
  logic        hit_nv_prot_w;
  logic        hit_nv_opt_w;
  logic        hit_key_w;
  logic        mapped_w;
  logic        lane0_w;
  logic [2:0]  key_idx_w;
  fsl_byte_t   wbyte_w;

  assign setup_w      = psel_i && !penable_i;
  assign access_w     = psel_i && penable_i;
  assign wr_w         = access_w && pwrite_i;
  assign rd_w         = access_w && !pwrite_i;
  assign hit_opt_w    = (paddr_i == byte_addr(`FSL_IDX_OPT));
  assign hit_cfg_w    = (paddr_i == byte_addr(`FSL_IDX_CFG));
  assign hit_prot_w   = (paddr_i == byte_addr(`FSL_IDX_PROT));
  assign hit_stat_w   = (paddr_i == byte_addr(`FSL_IDX_STATUS));
  assign hit_nv_prot_w = (paddr_i == byte_addr(`FSL_IDX_NV_PROT));
  assign hit_nv_opt_w  = (paddr_i == byte_addr(`FSL_IDX_NV_OPT));
  assign hit_key_w    = (paddr_i >= byte_addr(`FSL_IDX_KEY_FIRST)) &&
                        (paddr_i <= byte_addr(`FSL_IDX_KEY_LAST));
  assign mapped_w     = hit_opt_w || hit_cfg_w || hit_prot_w ||
                        hit_stat_w || hit_nv_prot_w || hit_nv_opt_w ||
                        hit_key_w;
  assign lane0_w      = pstrb_i[0];
  assign key_idx_w    = paddr_i[4:2];
  assign wbyte_w      = pwdata_i[7:0];

  // -------------------------------------------------------------------------
  // Reset copy of the nonvolatile bytes
  // -------------------------------------------------------------------------

  fsl_ld_if ld_if ();

  fsl_nv_loader u_loader (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .nv_req_o   (nv_req_o),
    .nv_addr_o  (nv_addr_o),
    .nv_data_i  (nv_data_i),
    .nv_valid_i (nv_valid_i),
    .ld         (ld_if.loader)
  );

  logic        loaded_w;
  logic        loaded_q;
  logic        load_pulse_w;

  assign loaded_w     = ld_if.done;
  assign load_pulse_w = loaded_w && !loaded_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      loaded_q <= 1'b0;
    end else begin
      loaded_q <= loaded_w;
    end
  end

  // -------------------------------------------------------------------------
  // Working option and protection registers
  // -------------------------------------------------------------------------

  fsl_byte_t   opt_q;
  fsl_byte_t   prot_q;
  logic        key_en_w;

  // R1: option copy
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      opt_q <= `FSL_RESET_BYTE;
    end else if (load_pulse_w) begin
      opt_q <= ld_if.opt;
    end
  end

  // R1: protection copy
  // Software writes are ignored until the copy lands, so a write issued
  // right after reset is dropped rather than overwritten by the late copy.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prot_q <= `FSL_RESET_BYTE;
    end else if (load_pulse_w) begin
      prot_q <= ld_if.prot;
    end else if (wr_w && hit_prot_w && lane0_w && loaded_q) begin
      prot_q <= wbyte_w;
    end
  end

  // R5: key path gate
  assign key_en_w = opt_q[`FSL_OPT_KEY_EN] && loaded_q;

  // -------------------------------------------------------------------------
  // Key access window
  // -------------------------------------------------------------------------

  logic        key_access_enable_q;
  logic        src_ok_w;
  logic        cfg_wr_w;
  logic        open_w;
  logic        close_w;
  logic        key_wr_w;
  logic        key_refuse_w;
  logic        key_match_w;
  logic        key_fail_w;

  // R4: secure code only
  assign src_ok_w     = secure_exec_i && !debug_access_i;
  assign cfg_wr_w     = wr_w && hit_cfg_w && lane0_w;
  assign open_w       = cfg_wr_w && wbyte_w[`FSL_CFG_KEY_ACC] &&
                        !key_access_enable_q && key_en_w && src_ok_w;
  assign close_w      = cfg_wr_w && !wbyte_w[`FSL_CFG_KEY_ACC] && key_access_enable_q;
  assign key_wr_w     = wr_w && hit_key_w && lane0_w && key_access_enable_q &&
                        src_ok_w;
  // R4: debug refused
  assign key_refuse_w = wr_w && (hit_key_w || hit_cfg_w) && !src_ok_w;

  // R5: window stays shut
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      key_access_enable_q <= 1'b0;
    end else if (!key_en_w || close_w) begin
      key_access_enable_q <= 1'b0;
    end else if (open_w) begin
      key_access_enable_q <= 1'b1;
    end
  end

  // R3: compare entered key
  fsl_key_cmp u_key_cmp (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .clear_i (open_w),
    .wr_i    (key_wr_w),
    .idx_i   (key_idx_w),
    .data_i  (wbyte_w),
    .check_i (close_w && key_en_w),
    .key_i   (ld_if.key),
    .match_o (key_match_w),
    .fail_o  (key_fail_w)
  );

  // -------------------------------------------------------------------------
  // Security state
  // -------------------------------------------------------------------------

  logic        unsecured_q;
  logic        erased_q;
  logic        loaded_unsec_w;

  // R7: unsecured pattern
  assign loaded_unsec_w = (ld_if.opt[1:0] == `FSL_SEC_UNSECURED);

  // R6: erase then blank
  // A blank verify only counts when it follows a mass erase of this reset
  // epoch; a blank check alone proves nothing about the array history.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      erased_q <= 1'b0;
    end else if (mass_erase_done_i) begin
      erased_q <= 1'b1;
    end
  end

  // R8: secured by default
  // The release is temporary: the next reset recopies the option byte.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      unsecured_q <= 1'b0;
    end else if (load_pulse_w) begin
      unsecured_q <= loaded_unsec_w;
    end else if (key_match_w && key_en_w) begin
      unsecured_q <= 1'b1;
    end else if (erased_q && blank_verified_i && loaded_q) begin
      unsecured_q <= 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // Sticky status flags
  // -------------------------------------------------------------------------

  logic        fail_q;
  logic        refuse_q;
  logic        stat_clr_w;

  assign stat_clr_w = wr_w && hit_stat_w && lane0_w;

  // A new event in the clearing cycle wins over the clear.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fail_q   <= 1'b0;
      refuse_q <= 1'b0;
    end else begin
      fail_q   <= key_fail_w ||
                  (fail_q && !(stat_clr_w && wbyte_w[`FSL_ST_KEY_FAIL]));
      refuse_q <= key_refuse_w ||
                  (refuse_q &&
                   !(stat_clr_w && wbyte_w[`FSL_ST_KEY_REFUSE]));
    end
  end

  // -------------------------------------------------------------------------
  // Read data and answer
  // -------------------------------------------------------------------------

  fsl_byte_t   cfg_w;
  fsl_byte_t   stat_w;
  fsl_byte_t   rsel_w;

  assign cfg_w  = {2'b00, key_access_enable_q, 5'b00000};
  assign stat_w = {3'b000, erased_q, refuse_q, fail_q, loaded_q,
                   !unsecured_q};

  // The key itself never reads back; its locations answer zero.
  assign rsel_w = hit_opt_w    ? opt_q :
                  hit_cfg_w    ? cfg_w :
                  hit_prot_w   ? prot_q :
                  hit_stat_w   ? stat_w :
                  hit_nv_prot_w ? ld_if.prot :
                  hit_nv_opt_w  ? ld_if.opt :
                  8'h00;

  // Every access completes in its first access cycle.
  assign pready_o  = 1'b1;
  assign pslverr_o = access_w && !mapped_w;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (setup_w && !pwrite_i) begin
      prdata_o <= {24'h00_0000, rsel_w};
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------

  logic        unused_w;

  assign unused_w = rd_w;

  // R8: secured report
  assign secured_o                 = !unsecured_q;
  assign load_done_o               = loaded_q;
  assign key_enable_o              = opt_q[`FSL_OPT_KEY_EN];
  assign vector_redirect_disable_o = opt_q[`FSL_OPT_NORED];
  assign protection_disable_o      = prot_q[`FSL_PROT_DIS];
  assign protect_select_o          = prot_q[7:1];

endmodule : fsl_flash_security

// ==== sim/fsl_flash_security_properties.sv ====
// Checker for the flash security option loader top.
// Assumes it is bound to fsl_flash_security and sees only its ports.
`timescale 1ns/10ps
`include "fsl_regs.svh"
module fsl_flash_security_properties
  import fsl_pkg::*;
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rstn_i,
  // APB and nonvolatile port
  input wire logic [17:0] paddr_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic        nv_req_o,
  input wire logic [15:0] nv_addr_o,
  input wire fsl_byte_t   nv_data_i,
  input wire logic        nv_valid_i,
  // Sources and state
  input wire logic        debug_access_i,
  input wire logic        blank_verified_i,
  input wire logic        secured_o,
  input wire logic        load_done_o,
  input wire logic        key_enable_o,
  input wire logic        vector_redirect_disable_o,
  input wire logic        protection_disable_o,
  input wire logic [6:0]  protect_select_o
);
  // ----
  // Shadow of the load sequence
  // ----
  logic [3:0]  cnt_q;
  fsl_byte_t   opt_q, prot_q;
  logic [15:0] exp_addr;
  wire         taken  = nv_req_o && nv_valid_i;
  wire         cfg_wr = psel_i && penable_i && pwrite_i &&
                        paddr_i == {`FSL_IDX_CFG, 2'b00};

  assign exp_addr = (cnt_q < 4'h8) ? 16'hFFB0 + 16'(cnt_q) :
                    (cnt_q == 4'h8) ? 16'hFFBD : 16'hFFBF;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q  <= 4'h0;
      opt_q  <= 8'h00;
      prot_q <= 8'h00;
    end else if (taken) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == 4'h8) prot_q <= nv_data_i;
      if (cnt_q == 4'h9) opt_q <= nv_data_i;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  AST_ADDR_ORDER: assert property (nv_req_o |-> nv_addr_o == exp_addr)
    else $error("loader fetched an unexpected address");
  AST_LOAD_DONE: assert property (taken && cnt_q == 4'h9 |-> ##[1:2] load_done_o)
    else $error("load done did not follow the last byte");
  AST_OPT_COPY: assert property ($rose(load_done_o) |->
      key_enable_o == opt_q[7] && vector_redirect_disable_o == opt_q[6])
    else $error("option outputs differ from the loaded byte");
  AST_PROT_COPY: assert property ($rose(load_done_o) |->
      {protect_select_o, protection_disable_o} == prot_q)
    else $error("protection outputs differ from the loaded byte");
  AST_UNSECURED: assert property ($rose(load_done_o) &&
      opt_q[1:0] == `FSL_SEC_UNSECURED |-> ##[0:1] !secured_o)
    else $error("unsecured pattern left the device secured");
  AST_SEC_UNTIL_LOAD: assert property (!load_done_o |-> secured_o)
    else $error("unsecured before the load finished");
  AST_SECURED_LOAD: assert property ($rose(load_done_o) &&
      opt_q[1:0] != `FSL_SEC_UNSECURED |-> secured_o [*2])
    else $error("secured pattern did not keep the device secured");
  AST_RELEASE_CAUSE: assert property ($fell(secured_o) |->
      $past(key_enable_o) || $past(blank_verified_i) ||
      $past(blank_verified_i, 2) || !$past(load_done_o, 2))
    else $error("security released without key path or blank check");
  AST_DEBUG_NO_RELEASE: assert property (cfg_wr && debug_access_i &&
      secured_o |=> secured_o [*2])
    else $error("debug access released security");
endmodule : fsl_flash_security_properties

bind fsl_flash_security fsl_flash_security_properties u_props (
  .clk_i, .rstn_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .nv_req_o,
  .nv_addr_o, .nv_data_i, .nv_valid_i, .debug_access_i, .blank_verified_i,
  .secured_o, .load_done_o, .key_enable_o, .vector_redirect_disable_o,
  .protection_disable_o, .protect_select_o
);

// ==== sim/fsl_flash_security_tb.sv ====
// Self-checking bench for the flash security option loader top.
// Assumes the bench answers the nonvolatile read port itself.
`timescale 1ns/10ps
`include "fsl_regs.svh"
module fsl_flash_security_tb
  import fsl_pkg::*;
;
  localparam logic [63:0] KEY = 64'h8877_6655_4433_2211;
  logic        clk_i = 1'b0, rstn_i = 1'b0;
  logic [17:0] paddr_i = 18'h00000;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [3:0]  pstrb_i = 4'hF;
  logic        pready_o, pslverr_o, nv_req_o, er;
  logic [15:0] nv_addr_o;
  fsl_byte_t   nv_data_i = 8'h00, nv_opt = 8'h00, nv_prot = 8'h00;
  logic        nv_valid_i = 1'b0, secure_exec_i = 1'b1;
  logic        debug_access_i = 1'b0, mass_erase_done_i = 1'b0;
  logic        blank_verified_i = 1'b0, secured_o, load_done_o;
  logic        key_enable_o, vector_redirect_disable_o;
  logic        protection_disable_o;
  logic [6:0]  protect_select_o;
  int          err_count = 0, check_count = 0;

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  fsl_flash_security dut (
    .clk_i, .rstn_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
    .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .nv_req_o, .nv_addr_o,
    .nv_data_i, .nv_valid_i, .secure_exec_i, .debug_access_i,
    .mass_erase_done_i, .blank_verified_i, .secured_o, .load_done_o,
    .key_enable_o, .vector_redirect_disable_o, .protection_disable_o,
    .protect_select_o
  );

  // ----
  // Array model and bus tasks
  // ----
  function automatic fsl_byte_t nv_byte(input logic [15:0] a);
    if (a[15:3] == 13'h1FF6) return KEY[8*a[2:0] +: 8];
    if (a == `FSL_IDX_NV_PROT) return nv_prot;
    if (a == `FSL_IDX_NV_OPT) return nv_opt;
    return 8'h00;
  endfunction : nv_byte

  // Off the answer the data lines toggle, so a stale byte never passes.
  always @(posedge clk_i) begin
    nv_valid_i <= nv_req_o && !nv_valid_i;
    if (nv_req_o && !nv_valid_i) nv_data_i <= nv_byte(nv_addr_o);
    else nv_data_i <= ~nv_data_i;
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic xfer(input logic [15:0] idx, input logic w,
                      input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    paddr_i   <= {idx, 2'b00};
    pwrite_i  <= w;
    pwdata_i  <= d;
    pstrb_i   <= s;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 64);
    if (pready_o !== 1'b1) begin
      err_count++;
      end_of_test();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    xfer(idx, 1'b1, d, 4'hF);
  endtask : wr

  task automatic rchk(input string nm, input logic [15:0] idx,
                      input logic [31:0] e);
    xfer(idx, 1'b0, 32'h0, 4'hF);
    chk(nm, rd, e);
  endtask : rchk

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  task automatic do_reset(input fsl_byte_t opt, prot);
    int n;
    @(posedge clk_i);
    nv_opt  <= opt;
    nv_prot <= prot;
    rstn_i  <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (n = 0; n < 100 && load_done_o !== 1'b1; n++) @(posedge clk_i);
    if (load_done_o !== 1'b1) begin
      err_count++;
      end_of_test();
    end
    @(negedge clk_i);
  endtask : do_reset

  task automatic key_seq(input logic [63:0] k);
    wr(`FSL_IDX_CFG, 32'h20);
    for (int i = 0; i < 8; i++)
      wr(16'(`FSL_IDX_KEY_FIRST + i), {24'h0, k[8*i +: 8]});
    wr(`FSL_IDX_CFG, 32'h00);
    settle(2);
  endtask : key_seq

  task automatic pulse_erase(input logic erase);
    @(posedge clk_i);
    mass_erase_done_i <= erase;
    @(posedge clk_i);
    mass_erase_done_i <= 1'b0;
    blank_verified_i  <= 1'b1;
    @(posedge clk_i);
    blank_verified_i <= 1'b0;
    settle(1);
  endtask : pulse_erase

  initial begin
    for (int s = 0; s < 4; s++) begin
      do_reset(8'h40 | 8'(s), 8'h81);
      chk("secured", secured_o, s != 2);
      chk("redirect", vector_redirect_disable_o, 1'b1);
      rchk("option", `FSL_IDX_OPT, 32'h40 | 32'(s));
      rchk("nv_option", `FSL_IDX_NV_OPT, 32'h40 | 32'(s));
      $display("test security field %0d done", s);
    end
    do_reset(8'h80, 8'h5B);
    chk("prot_out", {protect_select_o, protection_disable_o}, 8'h5B);
    chk("key_enable", key_enable_o, 1'b1);
    rchk("prot", `FSL_IDX_PROT, 32'h5B);
    rchk("nv_prot", `FSL_IDX_NV_PROT, 32'h5B);
    rchk("key_read", `FSL_IDX_KEY_FIRST, 32'h0);
    rchk("status", `FSL_IDX_STATUS, 32'h03);
    xfer(16'h0000, 1'b0, 32'h0, 4'hF);
    chk("unmapped", er, 1'b1);
    debug_access_i <= 1'b1;
    key_seq(KEY);
    debug_access_i <= 1'b0;
    secure_exec_i  <= 1'b0;
    key_seq(KEY);
    chk("secured", secured_o, 1'b1);
    secure_exec_i <= 1'b1;
    rchk("status", `FSL_IDX_STATUS, 32'h0B);
    wr(`FSL_IDX_STATUS, 32'h08);
    rchk("status", `FSL_IDX_STATUS, 32'h03);
    key_seq(KEY ^ 64'h0100_0000_0000_0000);
    chk("secured", secured_o, 1'b1);
    rchk("status", `FSL_IDX_STATUS, 32'h07);
    key_seq(KEY);
    chk("secured", secured_o, 1'b0);
    rchk("status", `FSL_IDX_STATUS, 32'h06);
    wr(`FSL_IDX_PROT, 32'h3C);
    xfer(`FSL_IDX_PROT, 1'b1, 32'hFF, 4'hE);
    settle(1);
    chk("prot_out", {protect_select_o, protection_disable_o}, 8'h3C);
    wr(`FSL_IDX_OPT, 32'h00);
    rchk("option", `FSL_IDX_OPT, 32'h80);
    $display("test key path done");
    do_reset(8'h03, 8'h00);
    key_seq(KEY);
    chk("secured", secured_o, 1'b1);
    pulse_erase(1'b0);
    chk("secured", secured_o, 1'b1);
    pulse_erase(1'b1);
    chk("secured", secured_o, 1'b0);
    rchk("status", `FSL_IDX_STATUS, 32'h12);
    do_reset(8'h03, 8'h00);
    chk("secured", secured_o, 1'b1);
    $display("test erase path done");
    end_of_test();
  end
endmodule : fsl_flash_security_tb
